// *** inc/ssq_defs.svh ***
// Constants of the start-up sequencer and setpoint select block
`ifndef SSQ_DEFS_SVH
`define SSQ_DEFS_SVH
`define SSQ_CLK_MHZ         200
`define SSQ_INIT_MS         5
`define SSQ_INIT_CYC        (`SSQ_INIT_MS * 1000 * `SSQ_CLK_MHZ)
`define SSQ_MIN_DLY_MS      2
`define SSQ_MIN_DLY_CYC     (`SSQ_MIN_DLY_MS * 1000 * `SSQ_CLK_MHZ)
`define SSQ_US_CYC          `SSQ_CLK_MHZ
`define SSQ_MV_W            13
`define SSQ_MV_MIN          13'd600
`define SSQ_MV_MAX          13'd5000
`define SSQ_MV_LOW          13'd1200
`define SSQ_MV_OPEN         13'd1500
`define SSQ_MV_HIGH         13'd3300
`define SSQ_RCODE_W         5
`define SSQ_RCODE_NUM       31
`endif

// *** inc/ssq_pkg.sv ***
// Types of the start-up sequencer and setpoint select block
package ssq_pkg;
  typedef enum logic [1:0] {
    SSQ_PIN_LOW,
    SSQ_PIN_OPEN,
    SSQ_PIN_HIGH,
    SSQ_PIN_RES
  } ssq_pin_t;

  typedef struct packed {
    ssq_pin_t   mode;
    logic [4:0] rcode;
  } ssq_strap_t;

  typedef struct packed {
    logic        valid;
    logic        restore;
    logic        vout_wr;
    logic [12:0] vout_mv;
  } ssq_cmd_t;

  typedef struct packed {
    logic        valid;
    logic [12:0] vout_mv;
  } ssq_nvm_t;
endpackage

// *** core/ssq_sequencer.sv ***
// Start-up sequencer with output setpoint selection and soft-start timing
`timescale 1ns/1ps
`include "ssq_defs.svh"
module ssq_sequencer #(
  parameter int unsigned INIT_CYC    = `SSQ_INIT_CYC,
  parameter int unsigned MIN_DLY_CYC = `SSQ_MIN_DLY_CYC
) (
  input  wire logic              clock_i,
  input  wire logic              rstn_i,
  input  wire logic              enable_i,
  input  wire ssq_pkg::ssq_strap_t output_level_select_pin_i,
  input  wire ssq_pkg::ssq_nvm_t nvm_i,
  input  wire ssq_pkg::ssq_cmd_t cmd_i,
  input  wire logic [15:0]       ss_delay_us_i,
  input  wire logic [15:0]       ss_ramp_us_i,
  output logic                   ready_o,
  output logic                   ramping_o,
  output logic                   ramp_done_o,
  output logic [12:0]            vout_target_o,
  output logic [12:0]            vout_ref_o,
  output logic [13:0]            output_ceiling_limit_o
);
  import ssq_pkg::*;

  typedef enum logic [2:0] {
    ST_MEMCHK, ST_PINCHK, ST_READY, ST_DELAY, ST_RAMP, ST_ON
  } ssq_state_t;

  // Resistor code to millivolts
  function automatic logic [12:0] rcode_mv(input logic [4:0] c);
    logic [12:0] v;
    v = 13'h0000;
    case (c)
      5'd0:  v = 13'd600;   5'd1:  v = 13'd700;   5'd2:  v = 13'd750;
      5'd3:  v = 13'd800;   5'd4:  v = 13'd900;   5'd5:  v = 13'd1000;
      5'd6:  v = 13'd1100;  5'd7:  v = 13'd1200;  5'd8:  v = 13'd1250;
      5'd9:  v = 13'd1300;  5'd10: v = 13'd1400;  5'd11: v = 13'd1500;
      5'd12: v = 13'd1600;  5'd13: v = 13'd1700;  5'd14: v = 13'd1800;
      5'd15: v = 13'd1900;  5'd16: v = 13'd2000;  5'd17: v = 13'd2100;
      5'd18: v = 13'd2200;  5'd19: v = 13'd2300;  5'd20: v = 13'd2400;
      5'd21: v = 13'd2500;  5'd22: v = 13'd2600;  5'd23: v = 13'd2700;
      5'd24: v = 13'd2800;  5'd25: v = 13'd2900;  5'd26: v = 13'd3000;
      5'd27: v = 13'd3100;  5'd28: v = 13'd3200;  5'd29: v = 13'd3300;
      5'd30: v = 13'd5000;
      default: v = 13'd600;
    endcase
    return v;
  endfunction

  function automatic logic [12:0] strap_mv(input ssq_strap_t s);
    logic [12:0] v;
    v = `SSQ_MV_OPEN;
    case (s.mode)
      SSQ_PIN_LOW:  v = `SSQ_MV_LOW;
      SSQ_PIN_OPEN: v = `SSQ_MV_OPEN;
      SSQ_PIN_HIGH: v = `SSQ_MV_HIGH;
      SSQ_PIN_RES:  v = rcode_mv(s.rcode);
      default:      v = `SSQ_MV_OPEN;
    endcase
    return v;
  endfunction

  ssq_state_t  state_q,  state_d;
  logic [31:0] cnt_q,    cnt_d;
  logic [31:0] us_q,     us_d;
  logic [12:0] tgt_q,    tgt_d;
  logic [12:0] ref_q,    ref_d;
  logic [13:0] ceil_q,   ceil_d;
  logic [31:0] dly_cyc;
  logic [31:0] ramp_cyc;
  logic [31:0] step_cyc;
  logic        cmd_ok;
  logic        restore;

  always_comb begin
    dly_cyc = 32'(ss_delay_us_i) * `SSQ_US_CYC;
    if (dly_cyc < MIN_DLY_CYC) begin
      dly_cyc = MIN_DLY_CYC;
    end
    ramp_cyc = 32'(ss_ramp_us_i) * `SSQ_US_CYC;
    // Cycles per millivolt step; zero ramp time steps every cycle
    step_cyc = (tgt_q == 13'h0000) ? 32'h1 : ramp_cyc / 32'(tgt_q);
    if (step_cyc == 32'h0) begin
      step_cyc = 32'h1;
    end
    // Commands are dropped while initialising
    cmd_ok  = cmd_i.valid && (state_q != ST_MEMCHK) &&
              (state_q != ST_PINCHK);
    restore = cmd_ok && cmd_i.restore;
  end

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    us_d    = us_q;
    tgt_d   = tgt_q;
    ref_d   = ref_q;
    ceil_d  = ceil_q;
    // A restore in the same command outranks the write
    if (cmd_ok && cmd_i.vout_wr && !cmd_i.restore &&
        cmd_i.vout_mv >= `SSQ_MV_MIN && cmd_i.vout_mv <= `SSQ_MV_MAX) begin
      tgt_d = cmd_i.vout_mv;
    end
    case (state_q)
      ST_MEMCHK: begin
        cnt_d = cnt_q + 32'h1;
        if (cnt_q + 32'h1 >= INIT_CYC) begin
          if (nvm_i.valid) begin
            tgt_d = nvm_i.vout_mv;
          end
          cnt_d   = 32'h0;
          state_d = ST_PINCHK;
        end
      end
      ST_PINCHK: begin
        // Pin values override stored ones, as the last load wins
        tgt_d   = strap_mv(output_level_select_pin_i);
        ceil_d  = 14'(strap_mv(output_level_select_pin_i)) +
                  14'(strap_mv(output_level_select_pin_i) / 13'd10);
        state_d = ST_READY;
      end
      ST_READY: begin
        ref_d = 13'h0000;
        cnt_d = 32'h0;
        if (enable_i) begin
          state_d = ST_DELAY;
        end
      end
      ST_DELAY: begin
        cnt_d = cnt_q + 32'h1;
        if (!enable_i) begin
          state_d = ST_READY;
        end else if (cnt_q + 32'h1 >= dly_cyc) begin
          cnt_d   = 32'h0;
          us_d    = 32'h0;
          state_d = ST_RAMP;
        end
      end
      ST_RAMP: begin
        us_d = us_q + 32'h1;
        if (!enable_i) begin
          state_d = ST_READY;
        end else if (ref_q >= tgt_q) begin
          ref_d   = tgt_q;
          state_d = ST_ON;
        end else if (us_q + 32'h1 >= step_cyc) begin
          us_d  = 32'h0;
          ref_d = ref_q + 13'd1;
        end
      end
      ST_ON: begin
        ref_d = tgt_q;
        if (!enable_i) begin
          state_d = ST_READY;
        end
      end
      default: state_d = ST_MEMCHK;
    endcase
    if (restore) begin
      cnt_d   = 32'h0;
      ref_d   = 13'h0000;
      state_d = ST_MEMCHK;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= ST_MEMCHK;
      cnt_q   <= 32'h0;
      us_q    <= 32'h0;
      tgt_q   <= `SSQ_MV_OPEN;
      ref_q   <= 13'h0000;
      ceil_q  <= 14'h0000;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      us_q    <= us_d;
      tgt_q   <= tgt_d;
      ref_q   <= ref_d;
      ceil_q  <= ceil_d;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ready_o                <= 1'b0;
      ramping_o              <= 1'b0;
      ramp_done_o            <= 1'b0;
      vout_target_o          <= 13'h0000;
      vout_ref_o             <= 13'h0000;
      output_ceiling_limit_o <= 14'h0000;
    end else begin
      ready_o                <= (state_d != ST_MEMCHK) &&
                                (state_d != ST_PINCHK);
      ramping_o              <= state_d == ST_RAMP;
      ramp_done_o            <= state_d == ST_ON;
      vout_target_o          <= tgt_d;
      vout_ref_o             <= ref_d;
      output_ceiling_limit_o <= ceil_d;
    end
  end
endmodule

// *** testbench/ssq_host_model.sv ***
// Host model driving the enable line and bus commands
`timescale 1ns/1ps
module ssq_host_model
(
  input  wire logic         clock_i,
  output ssq_pkg::ssq_cmd_t cmd_o,
  output logic              enable_o
);
  import ssq_pkg::*;
  initial begin
    cmd_o = '0;
    enable_o = 1'b0;
  end
  // The bench clock runs free and stable, so enable may change at any falling edge
  task automatic set_en(input logic v);
    @(negedge clock_i);
    enable_o = v;
  endtask
  // Idle command fields toggle so stale values are never mistaken for data
  task automatic send(input logic rs, input logic wr, input logic [12:0] mv);
    @(negedge clock_i);
    cmd_o = {1'b1, rs, wr, mv};
    @(negedge clock_i);
    cmd_o = {1'b0, ~cmd_o[14:0]};
  endtask
endmodule

// *** testbench/ssq_monitor.sv ***
// Port checker of the start-up sequencer
`timescale 1ns/1ps
module ssq_monitor #(
  parameter int unsigned MIN_DLY_CYC = 10
) (
  input wire logic              clock_i,
  input wire logic              rstn_i,
  input wire logic              enable_i,
  input wire ssq_pkg::ssq_cmd_t cmd_i,
  input wire ssq_pkg::ssq_nvm_t nvm_i,
  input wire logic              ready_o,
  input wire logic              ramping_o,
  input wire logic              ramp_done_o,
  input wire logic [12:0]       vout_target_o,
  input wire logic [12:0]       vout_ref_o
);
  import ssq_pkg::*;
  logic wr_v;
  logic in_rng;
  assign wr_v = ready_o && cmd_i.valid && cmd_i.vout_wr && !cmd_i.restore;
  assign in_rng = cmd_i.vout_mv >= 13'h0258 && cmd_i.vout_mv <= 13'h1388;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  idle_init_a: assert property (
    !ready_o |-> !ramping_o && !ramp_done_o)
    else $error("ramp active before ready");
  ref_init_a: assert property (
    !ready_o |-> vout_ref_o == 13'h0000)
    else $error("reference moved before ready");
  pre_delay_a: assert property (
    $rose(ramping_o) |-> $past(enable_i, MIN_DLY_CYC) && $past(enable_i))
    else $error("ramp began before minimum delay");
  ramp_end_a: assert property (
    $rose(ramp_done_o) |-> $past(ramping_o) && vout_ref_o == vout_target_o)
    else $error("ramp ended off target");
  ramp_mono_a: assert property (
    ramping_o |=> vout_ref_o >= $past(vout_ref_o))
    else $error("reference fell during ramp");
  restore_drop_a: assert property (
    ready_o && cmd_i.valid && cmd_i.restore |=> !ready_o)
    else $error("restore did not repeat memory check");
  write_ok_a: assert property (
    wr_v && in_rng |=> vout_target_o == $past(cmd_i.vout_mv))
    else $error("legal target write not taken");
  write_bad_a: assert property (
    wr_v && !in_rng |=> $stable(vout_target_o))
    else $error("illegal target write taken");
  nvm_load_a: assert property (
    $rose(ready_o) && $past(nvm_i.valid) |->
      $past(vout_target_o) == $past(nvm_i.vout_mv))
    else $error("stored target not loaded before pins");
endmodule
bind ssq_sequencer ssq_monitor #(.MIN_DLY_CYC(MIN_DLY_CYC)) mon (.clock_i,
  .rstn_i, .enable_i, .cmd_i, .nvm_i, .ready_o, .ramping_o, .ramp_done_o,
  .vout_target_o, .vout_ref_o);

// *** testbench/tb.sv ***
// Self-checking bench of the start-up sequencer
`timescale 1ns/1ps
module tb;
  import ssq_pkg::*;
  logic        clock_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        enable_i;
  ssq_cmd_t    cmd_i;
  ssq_strap_t  strap = '{SSQ_PIN_HIGH, 5'h00};
  ssq_nvm_t    nvm = '{1'b1, 13'h03e8};
  logic [15:0] dly_us = 16'h0000;
  logic [15:0] ramp_us = 16'h0000;
  localparam int INIT = 20;
  localparam int MIN_DLY = 10;
  logic        ready_o;
  logic        ramping_o;
  logic        ramp_done_o;
  logic [12:0] tgt;
  logic [12:0] vref;
  logic [13:0] ceil;
  int          n_mismatch = 0;
  int          num_checks = 0;
  always #2.5 clock_i = ~clock_i;
  ssq_host_model host (.clock_i, .cmd_o(cmd_i), .enable_o(enable_i));
  ssq_sequencer #(.INIT_CYC(INIT), .MIN_DLY_CYC(MIN_DLY)) DUT (.clock_i,
    .rstn_i, .enable_i, .output_level_select_pin_i(strap), .nvm_i(nvm),
    .cmd_i, .ss_delay_us_i(dly_us), .ss_ramp_us_i(ramp_us), .ready_o,
    .ramping_o, .ramp_done_o, .vout_target_o(tgt), .vout_ref_o(vref),
    .output_ceiling_limit_o(ceil));
  task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Waits for ready (0), ramping (1) or ramp done (2) and counts cycles
  task automatic wt(input int sel, output int n);
    n = 0;
    do begin
      @(posedge clock_i);
      #1 n++;
      if (n > 8000) begin
        n_mismatch++;
        print_verdict();
      end
    end while (sel == 0 ? ready_o !== 1'b1 : sel == 1 ?
               ramping_o !== 1'b1 : ramp_done_o !== 1'b1);
  endtask
  task automatic cmd(input logic rs, input logic wr, input logic [12:0] mv);
    host.send(rs, wr, mv);
    @(negedge clock_i);
  endtask
  task automatic ramp(input logic [12:0] mv, input int rc, output int n);
    int m;
    wt(1, n);
    wt(2, m);
    chk(m >= rc && m <= rc + 2, 1'b1);
    chk(vref, mv);
  endtask
  task automatic s_power();
    int n;
    // A restore in mid-check must not restart the count
    fork
      begin
        repeat (10) @(negedge clock_i);
        cmd(1'b1, 1'b1, 13'h0258);
      end
      wt(0, n);
    join
    chk(n >= INIT && n <= INIT + 2, 1'b1);
    chk(tgt, 13'h0ce4);
    chk(ceil, 14'h0e2e);
    ramp(13'h0ce4, 3300, n);
    chk(n >= MIN_DLY && n <= MIN_DLY + 3, 1'b1);
  endtask
  task automatic s_write();
    logic [12:0] wv [4] = '{13'h1388, 13'h0257, 13'h0258, 13'h1389};
    logic [12:0] ev [4] = '{13'h1388, 13'h1388, 13'h0258, 13'h0258};
    host.set_en(1'b0);
    for (int i = 0; i < 4; i++) begin
      cmd(1'b0, 1'b1, wv[i]);
      chk(tgt, ev[i]);
    end
    chk(ceil, 14'h0e2e);
  endtask
  task automatic s_restore();
    ssq_strap_t sp [4] = '{'{SSQ_PIN_RES, 5'h1e}, '{SSQ_PIN_LOW, 5'h00},
                           '{SSQ_PIN_OPEN, 5'h00}, '{SSQ_PIN_RES, 5'h00}};
    logic [12:0] mv [4] = '{13'h1388, 13'h04b0, 13'h05dc, 13'h0258};
    int n;
    strap = sp[0];
    repeat (3) @(negedge clock_i);
    chk(tgt, 13'h0258);
    for (int i = 0; i < 4; i++) begin
      @(negedge clock_i);
      strap = sp[i];
      cmd(1'b1, 1'b1, 13'h0300);
      chk(ready_o, 1'b0);
      chk(tgt, i == 0 ? 13'h0258 : mv[i - 1]);
      wt(0, n);
      chk(tgt, mv[i]);
      chk(ceil, {1'b0, mv[i]} + mv[i] / 10);
    end
  endtask
  task automatic s_delay();
    int n;
    @(negedge clock_i);
    dly_us = 16'h0001;
    ramp_us = 16'h0006;
    host.set_en(1'b1);
    ramp(13'h0258, 1200, n);
    chk(n >= 200 && n <= 204, 1'b1);
  endtask
  initial begin
    repeat (3) @(negedge clock_i);
    host.set_en(1'b1);
    rstn_i = 1'b1;
    s_power();
    s_write();
    s_restore();
    s_delay();
    print_verdict();
  end
endmodule
